// ### shared/hsl_consts.vh
// constants for the halfword / signed transfer controller
// assumes inclusion by bare name from rtl files
`ifndef HSL_CONSTS_VH
`define HSL_CONSTS_VH
`define HSL_PC_IDX      4'hF
`define HSL_PC_AHEAD    32'h00000008
`define HSL_COND_AL     4'hE
`define HSL_COND_NV     4'hF
`define HSL_BIT_P       24
`define HSL_BIT_U       23
`define HSL_BIT_I       22
`define HSL_BIT_W       21
`define HSL_BIT_L       20
`define HSL_BIT_S       6
`define HSL_BIT_H       5
`define HSL_XFER_CYCLES 1
`endif

// ### rtl/hsl_load_format.v
// load data formatter: lane select, sign or zero extension of halfwords, sign extension of bytes
// assumes word-wide data bus and halfword aligned addresses
`timescale 1ns/10ps
`default_nettype none
module hsl_load_format (
    // request
    input  wire [31:0] bus_data,
    input  wire [1:0]  addr_low,
    input  wire        big_endian,
    input  wire        is_signed,
    input  wire        is_half,
    // result
    output reg  [31:0] result
);
    reg [1:0]  lane;
    reg [7:0]  byte_sel;
    reg [15:0] half_sel;
    always @* begin
        lane     = big_endian ? ~addr_low : addr_low;
        byte_sel = bus_data[lane*8 +: 8];
        half_sel = (addr_low[1] ^ big_endian) ? bus_data[31:16] : bus_data[15:0];
        if (is_half) begin
            result = {{16{is_signed & half_sel[15]}}, half_sel};
        end else begin
            result = {{24{byte_sel[7]}}, byte_sel};
        end
    end
endmodule
`default_nettype wire

// ### rtl/hsl_half_signed_ctl.v
// execution control for halfword and signed byte/halfword transfers
// assumes a register file outside, address adder is inside; one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
`include "hsl_consts.vh"
module hsl_half_signed_ctl (
    // clock and reset
    input  wire        clock,
    input  wire        rstn,
    // instruction issue
    input  wire        instr_valid,
    input  wire [31:0] instr,
    input  wire [31:0] instr_addr,
    input  wire        cond_pass,
    input  wire        big_endian,
    // register file read values
    input  wire [31:0] base_value,
    input  wire [31:0] index_value,
    input  wire [31:0] source_value,
    // memory side
    input  wire [31:0] mem_rdata,
    input  wire        mem_abort,
    output reg  [31:0] mem_addr,
    output reg  [31:0] mem_wdata,
    output reg         mem_req,
    output reg         mem_write,
    output reg  [1:0]  mem_size,
    // register write back
    output reg         dest_we,
    output reg  [3:0]  dest_sel,
    output reg  [31:0] dest_value,
    output reg         base_we,
    output reg  [3:0]  base_sel,
    output reg  [31:0] base_value_out,
    // status
    output reg         data_abort_trap,
    output reg         illegal_form,
    output reg         done
);
    localparam ST_IDLE = 1'b0;
    localparam ST_XFER = 1'b1;

    reg        state;
    reg        p_load;
    reg        p_signed;
    reg        p_half;
    reg        p_wb;
    reg [3:0]  p_dest;
    reg [3:0]  p_base;
    reg [31:0] p_new_base;
    reg [1:0]  p_alow;

    // register field equals the program counter index
    function is_pc;
        input [3:0] sel;
        begin
            is_pc = (sel == `HSL_PC_IDX);
        end
    endfunction

    // bus size code: halfword or byte, no word size here
    function [1:0] size_code;
        input half;
        begin
            size_code = half ? 2'h1 : 2'h0;
        end
    endfunction


    wire [3:0] f_base  = instr[19:16];
    wire [3:0] f_dest  = instr[15:12];
    wire [3:0] f_index = instr[3:0];
    wire       f_p     = instr[`HSL_BIT_P];
    wire       f_u     = instr[`HSL_BIT_U];
    wire       f_i     = instr[`HSL_BIT_I];
    wire       f_w     = instr[`HSL_BIT_W];
    wire       f_l     = instr[`HSL_BIT_L];
    wire       f_s     = instr[`HSL_BIT_S];
    wire       f_h     = instr[`HSL_BIT_H];

    // base value with program_counter read as instruction plus eight
    wire [31:0] eff_base = is_pc(f_base) ?
                           instr_addr + `HSL_PC_AHEAD : base_value;
    wire [31:0] offset   = f_i ? {24'h000000, instr[11:8], instr[3:0]} : index_value;
    wire [31:0] moved    = f_u ? eff_base + offset : eff_base - offset;
    wire        wb_req   = f_w | ~f_p;

    // pre-index moves the address, post-index moves only the base
    wire [31:0] xfer_addr = f_p ? moved : eff_base;

    // forbidden forms are flagged, the transfer still runs as encoded
    // each form kept apart so a trace shows which one tripped
    wire bad_pc_index  = ~f_i & is_pc(f_index);
    wire bad_pc_dest   = is_pc(f_dest);
    wire bad_pc_base   = is_pc(f_base) & wb_req;
    wire bad_post_same = ~f_p & ~f_i & (f_index == f_base);
    wire bad_wb_load   = f_l & wb_req & (f_dest == f_base);
    wire bad_signed_st = ~f_l & f_s;

    // a flag only: software decides whether to trap on it
    wire bad_form = bad_pc_index
                  | bad_pc_dest
                  | bad_pc_base
                  | bad_post_same
                  | bad_wb_load
                  | bad_signed_st;

    wire [31:0] load_result;
    hsl_load_format u_fmt (
        .bus_data   (mem_rdata),
        .addr_low   (p_alow),
        .big_endian (big_endian),
        .is_signed  (p_signed),
        .is_half    (p_half),
        .result     (load_result)
    );

    always @(posedge clock) begin
        if (!rstn) begin
            state           <= ST_IDLE;
            p_load          <= 1'b0;
            p_signed        <= 1'b0;
            p_half          <= 1'b0;
            p_wb            <= 1'b0;
            p_dest          <= 4'h0;
            p_base          <= 4'h0;
            p_new_base      <= 32'h00000000;
            p_alow          <= 2'h0;
            mem_addr        <= 32'h00000000;
            mem_wdata       <= 32'h00000000;
            mem_req         <= 1'b0;
            mem_write       <= 1'b0;
            mem_size        <= 2'h0;
            dest_we         <= 1'b0;
            dest_sel        <= 4'h0;
            dest_value      <= 32'h00000000;
            base_we         <= 1'b0;
            base_sel        <= 4'h0;
            base_value_out  <= 32'h00000000;
            data_abort_trap <= 1'b0;
            illegal_form    <= 1'b0;
            done            <= 1'b0;
        end else begin
            dest_we         <= 1'b0;
            base_we         <= 1'b0;
            data_abort_trap <= 1'b0;
            done            <= 1'b0;
            mem_req         <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // condition failure: no-op, no memory cycle
                    if (instr_valid && cond_pass) begin
                        state        <= ST_XFER;
                        p_load       <= f_l;
                        p_signed     <= f_s;
                        p_half       <= f_h;
                        p_wb         <= wb_req;
                        p_dest       <= f_dest;
                        p_base       <= f_base;
                        p_new_base   <= moved;
                        p_alow       <= xfer_addr[1:0];
                        illegal_form <= bad_form;
                        mem_addr     <= xfer_addr;
                        mem_wdata    <= {2{source_value[15:0]}};
                        mem_req      <= 1'b1;
                        mem_write    <= ~f_l;
                        mem_size     <= size_code(f_h);
                    end else if (instr_valid) begin
                        done <= 1'b1;
                    end
                end
                ST_XFER: begin
                    // single data cycle, same as a word transfer
                    state <= ST_IDLE;
                    done  <= 1'b1;
                    if (mem_abort) begin
                        // base never written so its old value stands
                        data_abort_trap <= 1'b1;
                    end else begin
                        if (p_load) begin
                            dest_we    <= 1'b1;
                            dest_sel   <= p_dest;
                            dest_value <= load_result;
                        end
                        if (p_wb) begin
                            base_we        <= 1'b1;
                            base_sel       <= p_base;
                            base_value_out <= p_new_base;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### tb/hsl_mem.sv
// memory side stand-in, answers each transfer at once
// assumes the bench sets word and fail per transfer
`timescale 1ns/10ps
`default_nettype none
module hsl_mem (
    input  wire logic        mem_req, fail,
    input  wire logic [31:0] word,
    output logic      [31:0] mem_rdata,
    output logic             mem_abort
);
    assign mem_rdata = mem_req ? word : ~word; // idle bus never keeps data
    assign mem_abort = mem_req && fail;
endmodule
`default_nettype wire

// ### tb/hsl_ctl_chk.sv
// port assertions for the transfer controller
// assumes a bind onto hsl_half_signed_ctl
`timescale 1ns/10ps
`default_nettype none
module hsl_chk (
    input wire logic        clock, rstn, instr_valid, cond_pass, mem_abort, mem_req,
    input wire logic        mem_write, dest_we, base_we, data_abort_trap, done,
    input wire logic [31:0] instr, instr_addr, base_value, index_value,
    input wire logic [31:0] mem_addr, mem_wdata, dest_value
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    wire         take = instr_valid && !mem_req;
    wire  [31:0] bas = instr[19:16] == 4'hF ? instr_addr + 32'h8 : base_value;
    wire  [31:0] off = instr[22] ? {24'h0, instr[11:8], instr[3:0]} : index_value;
    logic [31:0] xa;
    always @(posedge clock) xa <= !instr[24] ? bas : instr[23] ? bas + off : bas - off;
    sequence s_go; take && cond_pass; endsequence
    sequence s_ok; mem_req && !mem_abort; endsequence
    property p_addr; s_go |=> mem_addr == xa; endproperty
    a_addr: assert property (p_addr) else $error("bad address");
    property p_cyc; s_go |=> mem_req ##1 done; endproperty
    a_cyc: assert property (p_cyc) else $error("not one cycle");
    property p_nop; take && !cond_pass |=> done && !mem_req; endproperty
    a_nop: assert property (p_nop) else $error("failed cond ran");
    property p_trap; mem_req && mem_abort |=> data_abort_trap; endproperty
    a_trap: assert property (p_trap) else $error("no trap");
    property p_keep; mem_req && mem_abort |=> !dest_we && !base_we; endproperty
    a_keep: assert property (p_keep) else $error("abort wrote");
    property p_post; (take && cond_pass && !instr[24]) ##1 s_ok |=> base_we; endproperty
    a_post: assert property (p_post) else $error("no writeback");
    property p_store; mem_req && mem_write |-> mem_wdata[31:16] == mem_wdata[15:0]; endproperty
    a_store: assert property (p_store) else $error("halves differ");
    property p_ext;
        dest_we && $past(instr[5], 2) |->
            dest_value[31:16] == ($past(instr[6], 2) ? {16{dest_value[15]}} : 16'h0);
    endproperty
    a_ext: assert property (p_ext) else $error("bad top bits");
endmodule
`default_nettype wire

// ### tb/tb_half_signed_load_store_ctl.sv
// self-checking bench for the transfer controller
// assumes hsl_mem answers every transfer with no wait
`timescale 1ns/10ps
`default_nettype none
module tb_half_signed_load_store_ctl;
    logic        clock = 0, rstn = 0, instr_valid = 0, cond_pass = 0, big_endian = 0, fail = 0;
    logic [31:0] instr = 0, instr_addr = 0, base_value = 0, index_value = 0, source_value = 0;
    logic [31:0] word = 0, mem_rdata, mem_addr, mem_wdata, dest_value, base_value_out;
    logic        mem_abort, mem_req, mem_write, dest_we, base_we, data_abort_trap, illegal_form, done;
    logic [1:0]  mem_size;
    logic [3:0]  dest_sel, base_sel;
    logic [31:0] qa[$], qd[$], qb[$], qm[$], qs[$];
    int          fails = 0, check_count = 0;
    hsl_half_signed_ctl dut (.*);
    hsl_mem u_mem (.*);
    initial forever #10 clock = ~clock;
    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    always @(posedge clock) begin
        if (mem_req) chk(mem_addr, qa.pop_front());
        if (mem_req && mem_write) chk(mem_wdata, qa.pop_front());
        if (mem_req) chk({mem_write, mem_size}, qm.pop_front());
        if (dest_we) chk(dest_value, qd.pop_front());
        if (dest_we) chk(dest_sel, qs.pop_front());
        if (base_we) chk(base_value_out, qb.pop_front());
        if (base_we) chk(base_sel, qs.pop_front());
        if (done) chk(illegal_form, 0);
    end
    // one transfer; forms stay legal, so illegal_form is checked low at each done
    task automatic op(input logic [1:0] kd, input logic pc);
        logic [31:0] b, o, e, w, x;
        logic [15:0] h;
        logic [7:0]  m, y;
        logic [3:0]  n;
        logic [1:0]  sh, s;
        logic        ld, p, u, i, wb, c, ab, be;
        sh = kd == 0 ? 2'b01 : kd;
        ld = kd != 0;
        {p, u, i, wb, ab, be, m} = 14'($urandom) & 14'h3FFE;
        c = $urandom_range(3) != 0;
        n = pc ? 4'hF : 4'($urandom_range(12));
        if (pc) {p, wb} = 2'b10;
        {w, x, o} = {$urandom, $urandom & 32'hFFFFFFFC, $urandom & 32'hFFFFFFFE};
        b = pc ? x + 32'h8 : $urandom & {31'h7FFFFFFF, !sh[0]};
        if (i) o = {24'h0, m};
        e = u ? b + o : b - o;
        s = (p ? e[1:0] : b[1:0]) ^ {2{be}};
        h = s[1] ? w[31:16] : w[15:0];
        y = 8'(w >> {s, 3'b000});
        if (c) qa.push_back(p ? e : b);
        if (c && !ld) qa.push_back({2{w[15:0]}});
        if (c) qm.push_back({29'h0, !ld, 1'b0, sh[0]});
        if (c && !ab && ld) qs.push_back({28'h0, 4'(n + 1)});
        if (c && !ab && (wb || !p)) qs.push_back({28'h0, n});
        if (c && !ab && ld) qd.push_back(sh == 2'b01 ? {16'h0, h} :
            sh[0] ? {{16{h[15]}}, h} : {{24{y[7]}}, y});
        if (c && !ab && (wb || !p)) qb.push_back(e);
        instr <= {7'h70, p, u, i, wb, ld, n, 4'(n + 1), i ? m[7:4] : 4'h0, 1'b1, sh, 1'b1,
            i ? m[3:0] : 4'(n + 2)};
        {instr_valid, instr_addr, base_value, index_value} <= {1'b1, x, pc ? ~b : b, o};
        {source_value, word, cond_pass, fail, big_endian} <= {w, w, c, ab, be};
        @(posedge clock);
        instr_valid <= 0;
        @(posedge clock);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        int k;
        k = $urandom(23827);
        repeat (8) @(posedge clock);
        rstn <= 1;
        repeat (150) for (k = 0; k < 4; k++) op(k[1:0], $urandom_range(7) == 0);
        repeat (4) @(posedge clock);
        chk(qa.size() + qd.size() + qb.size() + qm.size() + qs.size(), 0);
        give_verdict;
    end
    initial begin
        #100000;
        fails++;
        give_verdict;
    end
endmodule
bind hsl_half_signed_ctl hsl_chk u_chk (.*);
`default_nettype wire
